// *** src/pad_pkg.sv ***
// Constants and carriers for the pad configuration block
package pad_pkg;
  localparam logic [7:0] PAD_CONFIG_ADDR  = 8'h27;
  localparam logic [7:0] PAD_CONFIG_RESET = 8'h00;
  localparam int         BIT_CLK_DIS      = 7;
  localparam int         BIT_PULLUP       = 6;
  localparam int         BIT_LEVEL        = 5;
  localparam int         BIT_INTYPE       = 4;
  localparam int         STAMP_MODE_HI    = 3;
  localparam int         STAMP_MODE_LO    = 2;
  localparam int         IRQA_MODE_HI     = 1;
  localparam int         IRQA_MODE_LO     = 0;
  localparam logic [1:0] STAMP_OFF        = 2'h0;
  localparam logic [1:0] STAMP_IRQ_B      = 2'h1;
  localparam logic [1:0] STAMP_CLK        = 2'h2;
  localparam logic [1:0] STAMP_INPUT      = 2'h3;
  localparam logic [1:0] IRQA_CLK         = 2'h0;
  localparam logic [1:0] IRQA_BATT        = 2'h1;
  localparam logic [1:0] IRQA_IRQ         = 2'h2;
  localparam logic [1:0] IRQA_HIZ         = 2'h3;
  // Timing
  localparam longint     CLK_HZ           = 50_000_000;
  localparam longint     SAMPLE_RATE_HZ   = 16;
  localparam longint     SAMPLE_US_X10    = 305;   // Window length in tenths of a microsecond
  localparam longint     SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_RATE_HZ;
  // Rounds down so the pull-up never outlasts the window
  localparam longint     SAMPLE_WIN_CYC   = (SAMPLE_US_X10 * CLK_HZ) / 10_000_000 > 0
                                            ? (SAMPLE_US_X10 * CLK_HZ) / 10_000_000 : 1;
  localparam longint     CLK_OUT_BASE_HZ  = 32_768;

  typedef struct packed {
    logic       clock_out_disable;
    logic       stamp_pullup_select;
    logic       stamp_level_sense;
    logic       stamp_input_type;
    logic [1:0] stamp_pin_mode;
    logic [1:0] irq_a_pin_mode;
  } pad_config_t;

  typedef struct packed {
    logic o;
    logic oe;
  } pad_drive_t;
endpackage

// *** src/stamp_sync.sv ***
// Three-stage synchroniser with agreement check for the stamp pin
`timescale 1ns/10ps
module stamp_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level
);
  logic [2:0] stage;

  // First stage is read only by the second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= {stage[1:0], async_in};
      if (stage[1] == stage[2]) begin
        level <= stage[2];
      end
    end
  end
endmodule

// *** src/pad_io_ctrl.sv ***
// Pin input/output mode control for the clock, stamp and first interrupt pins
`timescale 1ns/10ps
// Summary of operation
// - Clock pin disable bit forces pin low.
// - Pull-up select picks 80k or 40k.
// - Level sense chooses rising or falling event.
// - Stamp mode: off, irq B, clock, input.
// - Stamp outputs drive only on main supply.
// - Stamp clock role outputs selected frequency.
// - Input type ignored outside input mode.
// - CMOS input direct, disabled on battery.
// - Switch mode samples at 16 Hz briefly.
// - Active stamp event triggers timestamp capture.
// - Stamp pin may also halt counting.
// - Irq A mode: clock, battery, irq, hi-z.
// - Irq A interrupt role open drain, both supplies.
// - Irq A clock role only on main supply.
// - Battery role pulls low on battery only.
// - Battery role follows switch state only.
// - Stop bit, or active pin when stop source is selected, stops oscillator.
// - Frequency select shared by all three pins.
module pad_io_ctrl #(
  parameter longint SAMPLE_PERIOD = pad_pkg::SAMPLE_PERIOD_CYC,
  parameter int     CNT_W         = 24
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       on_battery,
  input  wire logic       freq_clock,
  input  wire logic       irq_a_level_n,
  input  wire logic       irq_b_level_n,
  input  wire logic       stop_bit,
  input  wire logic       stop_source_select,
  input  wire logic       stamp_pin_in,
  output logic            stamp_pin_o,
  output logic            stamp_pin_oe,
  output logic            stamp_pullup_en,
  output logic            stamp_pullup_strong,
  output logic            stamp_event,
  output logic            osc_stop,
  output logic            clk_pin,
  output logic            irq_a_out_o,
  output logic            irq_a_out_oe
);
  typedef struct packed {
    pad_pkg::pad_config_t cfg;
    logic [7:0]           rdata;
    logic [CNT_W-1:0]     div_cnt;
    logic                 sampling;
    logic                 sample_armed;
    logic                 sw_level;
    logic                 prev_level;
    logic                 prev_valid;
    logic                 stamp_o;
    logic                 stamp_oe;
    logic                 pull_en;
    logic                 pull_strong;
    logic                 event_p;
    logic                 stop;
    logic                 clk_o;
    logic                 irqa_o;
    logic                 irqa_oe;
  } state_t;

  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(SAMPLE_PERIOD - 1);
  localparam logic [CNT_W-1:0] WIN_LAST    = CNT_W'(pad_pkg::SAMPLE_WIN_CYC - 1);

  state_t st;
  state_t next_st;
  logic   pin_sync;

  stamp_sync u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (stamp_pin_in),
    .level    (pin_sync)
  );

  function automatic logic is_active(input logic lvl, input logic sense);
    return sense ? ~lvl : lvl;
  endfunction

  logic       input_mode;
  logic       cmos_live;
  logic       cur_level;
  logic       cur_valid;

  always_comb begin
    next_st = st;
    next_st.event_p = 1'b0;
    // Register port
    if (reg_wr && reg_addr == pad_pkg::PAD_CONFIG_ADDR) begin
      next_st.cfg = pad_pkg::pad_config_t'(reg_wdata);
    end
    if (reg_rd && reg_addr == pad_pkg::PAD_CONFIG_ADDR) begin
      next_st.rdata = st.cfg;
    end else begin
      next_st.rdata = 8'h00;
    end

    input_mode = (st.cfg.stamp_pin_mode == pad_pkg::STAMP_INPUT);
    // Type bit matters only in input mode
    cmos_live  = input_mode && !st.cfg.stamp_input_type && !on_battery;

    // 16 Hz switch sampler, window with pull-up on
    if (st.div_cnt == PERIOD_LAST) begin
      next_st.div_cnt = '0;
    end else begin
      next_st.div_cnt = st.div_cnt + 1'b1;
    end
    next_st.sampling = input_mode && st.cfg.stamp_input_type && (st.div_cnt <= WIN_LAST);
    next_st.sample_armed = 1'b0;
    // Sample at window end so pull-up has settled
    if (st.sampling && !next_st.sampling) begin
      next_st.sw_level = pin_sync;
      next_st.sample_armed = 1'b1;
    end
    next_st.pull_en     = next_st.sampling;
    next_st.pull_strong = st.cfg.stamp_pullup_select;

    if (st.cfg.stamp_input_type) begin
      cur_level = st.sw_level;
      cur_valid = input_mode;
    end else begin
      cur_level = pin_sync;
      cur_valid = cmos_live;
    end

    // Edge detection; loss of validity resets history so no false edge
    if (!cur_valid) begin
      next_st.prev_valid = 1'b0;
    end else if (!st.cfg.stamp_input_type || st.sample_armed) begin
      next_st.prev_level = cur_level;
      next_st.prev_valid = 1'b1;
      if (st.prev_valid && is_active(cur_level, st.cfg.stamp_level_sense)
          && !is_active(st.prev_level, st.cfg.stamp_level_sense)) begin
        next_st.event_p = 1'b1;
      end
    end

    next_st.stop = stop_bit || (stop_source_select && cur_valid
                                && is_active(cur_level, st.cfg.stamp_level_sense));

    next_st.clk_o = st.cfg.clock_out_disable ? 1'b0 : freq_clock;

    // Stamp pin outputs
    next_st.stamp_oe = 1'b0;
    next_st.stamp_o  = 1'b0;
    case (st.cfg.stamp_pin_mode)
      pad_pkg::STAMP_IRQ_B: begin
        next_st.stamp_oe = !on_battery;
        next_st.stamp_o  = irq_b_level_n;
      end
      pad_pkg::STAMP_CLK: begin
        next_st.stamp_oe = !on_battery;
        next_st.stamp_o  = freq_clock;
      end
      default: begin
        next_st.stamp_oe = 1'b0;
      end
    endcase

    // First interrupt pin, open drain: drive only low
    next_st.irqa_o = 1'b0;
    case (st.cfg.irq_a_pin_mode)
      pad_pkg::IRQA_CLK:  next_st.irqa_oe = !on_battery && !freq_clock;
      pad_pkg::IRQA_BATT: next_st.irqa_oe = on_battery;
      pad_pkg::IRQA_IRQ:  next_st.irqa_oe = !irq_a_level_n;
      default:            next_st.irqa_oe = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st     <= '0;
      st.cfg <= pad_pkg::pad_config_t'(pad_pkg::PAD_CONFIG_RESET);
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata           = st.rdata;
  assign stamp_pin_o         = st.stamp_o;
  assign stamp_pin_oe        = st.stamp_oe;
  assign stamp_pullup_en     = st.pull_en;
  assign stamp_pullup_strong = st.pull_strong;
  assign stamp_event         = st.event_p;
  assign osc_stop            = st.stop;
  assign clk_pin             = st.clk_o;
  assign irq_a_out_o         = st.irqa_o;
  assign irq_a_out_oe        = st.irqa_oe;
endmodule

// *** sim/pad_io_ctrl_assertions.sv ***
// Port checker for the pad control block
`timescale 1ns/10ps
module pad_io_ctrl_assertions (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       on_battery,
  input wire logic       freq_clock,
  input wire logic       irq_a_level_n,
  input wire logic       stop_bit,
  input wire logic       stamp_pin_oe,
  input wire logic       stamp_pullup_en,
  input wire logic       stamp_event,
  input wire logic       osc_stop,
  input wire logic       clk_pin,
  input wire logic       irq_a_out_oe
);
  logic [7:0] cfg;
  logic       a_oe;
  wire        hit = reg_addr == pad_pkg::PAD_CONFIG_ADDR;
  wire  [7:0] rd_exp = (reg_rd && hit) ? cfg : 8'h00;
  wire        clk_exp = !cfg[7] && freq_clock;
  wire        s_oe = (cfg[3] ^ cfg[2]) && !on_battery;
  // Shadow copy, only the bus moves it
  always_ff @(posedge mclk) begin
    if (!rst_n)
      cfg <= 8'h00;
    else if (reg_wr && hit)
      cfg <= reg_wdata;
  end
  always_comb begin
    case (cfg[1:0])
      2'h0: a_oe = !on_battery && !freq_clock;
      2'h1: a_oe = on_battery;
      2'h2: a_oe = !irq_a_level_n;
      default: a_oe = 1'b0;
    endcase
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_read_data:
    assert property (rst_n |=> reg_rdata == $past(rd_exp)) else $error("read data wrong");
  a_clk_pin:
    assert property (rst_n |=> clk_pin == $past(clk_exp)) else $error("clock pin wrong");
  a_stamp_drive:
    assert property (rst_n |=> stamp_pin_oe == $past(s_oe)) else $error("stamp drive wrong");
  a_irq_a_drive:
    assert property (rst_n |=> irq_a_out_oe == $past(a_oe)) else $error("irq a drive wrong");
  a_event_pulse:
    assert property (stamp_event |=> !stamp_event) else $error("event too long");
  a_event_mode:
    assert property ((cfg[3:2] != 2'h3) [*2] |=> !stamp_event) else $error("event outside input");
  a_stop_forced:
    assert property (stop_bit |=> osc_stop) else $error("stop bit ignored");
  a_pullup_gate:
    assert property ((cfg[4:2] != 3'h7) [*2] |=> !stamp_pullup_en) else $error("stray pull-up");
endmodule
bind pad_io_ctrl pad_io_ctrl_assertions i_pad_io_ctrl_assertions (.mclk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .on_battery, .freq_clock, .irq_a_level_n, .stop_bit, .stamp_pin_oe,
  .stamp_pullup_en, .stamp_event, .osc_stop, .clk_pin, .irq_a_out_oe);

// *** sim/pad_far_side.sv ***
// Far side of the pads: switch or driver on stamp pin, host pull-up
`timescale 1ns/10ps
module pad_far_side (
  input  wire logic mclk,
  input  wire logic stamp_pin_o,
  input  wire logic stamp_pin_oe,
  input  wire logic stamp_pullup_en,
  input  wire logic ext_en,
  input  wire logic ext_level,
  input  wire logic irq_a_out_o,
  input  wire logic irq_a_out_oe,
  output logic      stamp_wire,
  output logic      irq_a_wire
);
  logic last = 1'b0;
  // Floating pin never holds its old level
  assign stamp_wire = stamp_pin_oe ? stamp_pin_o : ext_en ? ext_level : stamp_pullup_en ? 1'b1 : !last;
  assign irq_a_wire = irq_a_out_oe ? irq_a_out_o : 1'b1;
  always @(posedge mclk) last <= stamp_wire;
endmodule

// *** sim/pad_io_ctrl_tb.sv ***
// Self-checking bench for the pad control block
`timescale 1ns/10ps
module pad_io_ctrl_tb;
  localparam int PERIOD = 2000;
  logic       mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, on_battery = 1'b0, e;
  logic       freq_clock = 1'b0, irq_a_level_n = 1'b1, irq_b_level_n = 1'b1, stop_bit = 1'b0;
  logic       stop_source_select = 1'b0, ext_en = 1'b0, ext_level = 1'b0, rd_d = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, c, x;
  logic       stamp_wire, stamp_pin_o, stamp_pin_oe, stamp_pullup_en, stamp_pullup_strong;
  logic       stamp_event, osc_stop, clk_pin, irq_a_out_o, irq_a_out_oe, irq_a_wire;
  logic [7:0] expq[$];
  int         fails = 0, check_count = 0, evs = 0, run, top;
  always #10 mclk = ~mclk;
  pad_io_ctrl #(.SAMPLE_PERIOD(PERIOD)) i_pad_io_ctrl (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .on_battery, .freq_clock, .irq_a_level_n, .irq_b_level_n, .stop_bit,
    .stop_source_select, .stamp_pin_in(stamp_wire), .stamp_pin_o, .stamp_pin_oe, .stamp_pullup_en,
    .stamp_pullup_strong, .stamp_event, .osc_stop, .clk_pin, .irq_a_out_o, .irq_a_out_oe);
  pad_far_side i_pad_far_side (.mclk, .stamp_pin_o, .stamp_pin_oe, .stamp_pullup_en, .ext_en,
    .ext_level, .irq_a_out_o, .irq_a_out_oe, .stamp_wire, .irq_a_wire);
  task automatic chk(input logic [15:0] g, input logic [15:0] w, input string m);
    check_count++;
    if (g !== w) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, w);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] w);
    reg_addr <= a;
    reg_rd <= 1'b1;
    expq.push_back(w);
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic summarize();
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Read data lands one cycle after the strobe
  always @(posedge mclk) begin
    if (stamp_event === 1'b1) evs++;
    if (rd_d) begin
      x = expq.pop_front();
      chk(reg_rdata, x, "read data");
    end
    rd_d <= reg_rd;
  end
  initial begin
    void'($urandom(28839));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    wr(8'h26, 8'hff);
    rd(8'h27, 8'h00);
    @(posedge mclk);
    rd(8'h26, 8'h00);
    for (int i = 0; i < 6; i++) begin
      c = 8'($urandom);
      wr(8'h27, c);
      rd(8'h27, c);
    end
    for (int i = 0; i < 32; i++) begin
      c = {2'($urandom), 2'b00, 4'(i)};
      wr(8'h27, c);
      on_battery <= i[4];
      freq_clock <= 1'($urandom);
      irq_a_level_n <= 1'($urandom);
      irq_b_level_n <= 1'($urandom);
      repeat (3) @(posedge mclk);
      chk(clk_pin, !c[7] && freq_clock, "clock pin");
      chk(stamp_pullup_strong, c[6], "pull-up");
      chk(stamp_pin_oe, (c[3] ^ c[2]) && !on_battery, "stamp drive");
      if (stamp_pin_oe === 1'b1) chk(stamp_pin_o, c[2] ? irq_b_level_n : freq_clock, "stamp out");
      case (c[1:0])
        2'h0: e = on_battery || freq_clock;
        2'h1: e = !on_battery;
        2'h2: e = irq_a_level_n;
        default: e = 1'b1;
      endcase
      chk(irq_a_wire, e, "irq a pin");
    end
    stop_source_select <= 1'b1;
    ext_en <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      on_battery <= 1'b0;
      ext_level <= s[0];
      wr(8'h27, {2'b00, s[0], 5'h0c});
      repeat (10) @(posedge mclk);
      evs = 0;
      ext_level <= !s[0];
      repeat (10) @(posedge mclk);
      chk(16'(evs), 1, "active edge");
      chk(osc_stop, 1, "pin stop");
      ext_level <= s[0];
      repeat (10) @(posedge mclk);
      chk(16'(evs), 1, "idle edge");
      chk(osc_stop, 0, "pin run");
      on_battery <= 1'b1;
      ext_level <= !s[0];
      repeat (10) @(posedge mclk);
      chk(16'(evs), 1, "battery edge");
    end
    stop_bit <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(osc_stop, 1, "stop bit");
    stop_bit <= 1'b0;
    stop_source_select <= 1'b0;
    ext_level <= 1'b0;
    wr(8'h27, 8'h5e);
    repeat (2 * PERIOD) @(posedge mclk);
    evs = 0;
    top = 0;
    run = 0;
    ext_en <= 1'b0;
    repeat (3 * PERIOD) begin
      @(posedge mclk);
      run = stamp_pullup_en ? run + 1 : 0;
      if (run > top) top = run;
    end
    chk(16'(evs), 1, "switch open");
    chk(16'(top), 16'h05f5, "sample window");
    summarize();
  end
endmodule
